// *** core/lwd_if.sv ***
// Purpose: carrier of the locked settings between the option store and the counter
// Assumes: single clock domain
// Notes:   driven only by lwd_opt
`timescale 1ns/1ps
`default_nettype none
interface lwd_if;
  logic enable;
  logic clk_sel;
  logic to_sel;
  logic restart;
  modport opt (output enable, output clk_sel, output to_sel, output restart);
  modport core (input enable, input clk_sel, input to_sel, input restart);
endinterface
`default_nettype wire

// *** core/lwd_map.svh ***
// Purpose: constants for the liveness watchdog
// Assumes: 100 MHz module clock, low-power clock arrives as a strobe input
// Notes:   definitions only
`ifndef LWD_MAP_SVH
`define LWD_MAP_SVH

`define LWD_CNT_W        19
`define LWD_LP_SHORT     19'h00020
`define LWD_LP_LONG      19'h00100
`define LWD_BUS_SHORT    19'h02000
`define LWD_BUS_LONG     19'h40000
`define LWD_CNT_ZERO     19'h00000
`define LWD_CNT_ONE      19'h00001
`define LWD_RST_ENABLE   1'h1
`define LWD_RST_CLKSEL   1'h0
`define LWD_RST_TOSEL    1'h1
`define LWD_RST_PULSE_W  4
`define LWD_RST_PULSE    4'hF
`define LWD_HOLD_ZERO    4'h0
`define LWD_HOLD_ONE     4'h1
`define LWD_SYNC_W       2

`endif

// *** core/lwd_opt.sv ***
// Purpose: write-once option store for the liveness watchdog settings
// Assumes: write strobes are one-cycle pulses
// Notes:   the lock flags clear only on reset
`timescale 1ns/1ps
`default_nettype none
`include "lwd_map.svh"
module lwd_opt (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_opt1_wr,
  input  wire logic i_opt1_enable,
  input  wire logic i_opt1_to_sel,
  input  wire logic i_opt2_wr,
  input  wire logic i_opt2_clk_sel,
  lwd_if.opt        o_cfg
);
  logic enable_r, enable_nxt;
  logic to_sel_r, to_sel_nxt;
  logic clk_sel_r, clk_sel_nxt;
  logic lock1_r, lock1_nxt;
  logic lock2_r, lock2_nxt;
  logic restart_r, restart_nxt;

  always_comb begin
    enable_nxt  = enable_r;
    to_sel_nxt  = to_sel_r;
    clk_sel_nxt = clk_sel_r;
    lock1_nxt   = lock1_r;
    lock2_nxt   = lock2_r;
    restart_nxt = 1'h0;
    if (i_opt1_wr && !lock1_r) begin
      enable_nxt  = i_opt1_enable;
      to_sel_nxt  = i_opt1_to_sel;
      lock1_nxt   = 1'h1;
      restart_nxt = 1'h1;
    end
    if (i_opt2_wr && !lock2_r) begin
      clk_sel_nxt = i_opt2_clk_sel;
      lock2_nxt   = 1'h1;
      restart_nxt = 1'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_r  <= `LWD_RST_ENABLE;
      to_sel_r  <= `LWD_RST_TOSEL;
      clk_sel_r <= `LWD_RST_CLKSEL;
      lock1_r   <= 1'h0;
      lock2_r   <= 1'h0;
      restart_r <= 1'h0;
    end else begin
      enable_r  <= enable_nxt;
      to_sel_r  <= to_sel_nxt;
      clk_sel_r <= clk_sel_nxt;
      lock1_r   <= lock1_nxt;
      lock2_r   <= lock2_nxt;
      restart_r <= restart_nxt;
    end
  end

  assign o_cfg.enable  = enable_r;
  assign o_cfg.to_sel  = to_sel_r;
  assign o_cfg.clk_sel = clk_sel_r;
  assign o_cfg.restart = restart_r;
endmodule
`default_nettype wire

// *** core/lwd_pkg.sv ***
// Purpose: types for the liveness watchdog
// Assumes: nothing
// Notes:   constants live in lwd_map.svh
package lwd_pkg;
  typedef enum logic {LWD_CLK_LOWPOWER, LWD_CLK_BUS} lwd_clk_e;
  typedef logic [18:0] lwd_cnt_t;
endpackage

// *** core/lwd_top.sv ***
// Purpose: liveness watchdog that forces a system reset when not serviced
// Assumes: i_lp_tick is a one-cycle pulse per low-power clock period, synchronous to i_mclk
// Notes:   the reset-cause flag must live in always-on logic; here it survives
//          only the block's own overflow, it is cleared by i_rst_n (power-on class)
`timescale 1ns/1ps
`default_nettype none
`include "lwd_map.svh"
module lwd_top (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_lp_tick,
  input  wire logic i_cause_wr,
  input  wire logic i_opt1_wr,
  input  wire logic i_opt1_enable,
  input  wire logic i_opt1_to_sel,
  input  wire logic i_opt2_wr,
  input  wire logic i_opt2_clk_sel,
  input  wire logic i_debug_mode,
  input  wire logic i_stop_mode,
  input  wire logic i_other_reset,
  output logic      o_sys_reset,
  output logic      o_cause_watchdog,
  output logic      o_enable,
  output logic      o_clk_sel,
  output logic      o_to_sel
);
  // ****************************************
  // settings
  // ****************************************
  lwd_if cfg ();

  lwd_opt u_opt (
    .i_mclk         (i_mclk),
    .i_rst_n        (i_rst_n),
    .i_opt1_wr      (i_opt1_wr),
    .i_opt1_enable  (i_opt1_enable),
    .i_opt1_to_sel  (i_opt1_to_sel),
    .i_opt2_wr      (i_opt2_wr),
    .i_opt2_clk_sel (i_opt2_clk_sel),
    .o_cfg          (cfg)
  );

  function automatic lwd_pkg::lwd_cnt_t limit_of(input logic clk_sel, input logic to_sel);
    lwd_pkg::lwd_cnt_t lim;
    lim = `LWD_LP_LONG;
    if (clk_sel == lwd_pkg::LWD_CLK_LOWPOWER)
      lim = to_sel ? `LWD_LP_LONG : `LWD_LP_SHORT;
    else
      lim = to_sel ? `LWD_BUS_LONG : `LWD_BUS_SHORT;
    return lim;
  endfunction

  // ****************************************
  // counter state and decode
  // ****************************************
  lwd_pkg::lwd_cnt_t           cnt_r;
  lwd_pkg::lwd_cnt_t           cnt_nxt;
  logic                        stop_d_r;
  logic                        stop_d_nxt;
  logic                        step;
  logic                        stop_entry;
  logic                        ovf;
  lwd_pkg::lwd_cnt_t           limit;

  // ****************************************
  // reset pulse and cause state
  // ****************************************
  logic                        fire_r;
  logic                        fire_nxt;
  logic [`LWD_RST_PULSE_W-1:0] hold_r;
  logic [`LWD_RST_PULSE_W-1:0] hold_nxt;
  logic                        cause_r;
  logic                        cause_nxt;

  // ****************************************
  // settings mirror state
  // ****************************************
  logic                        en_r;
  logic                        en_nxt;
  logic                        clks_r;
  logic                        clks_nxt;
  logic                        tos_r;
  logic                        tos_nxt;

  // ****************************************
  // counter
  // ****************************************
  always_comb begin
    limit      = limit_of(cfg.clk_sel, cfg.to_sel);
    step       = (cfg.clk_sel == lwd_pkg::LWD_CLK_BUS) ? 1'h1 : i_lp_tick;
    stop_entry = i_stop_mode && !stop_d_r && (cfg.clk_sel == lwd_pkg::LWD_CLK_LOWPOWER);
    stop_d_nxt = i_stop_mode;
    cnt_nxt    = cnt_r;
    ovf        = 1'h0;
    if (i_cause_wr || cfg.restart) begin
      cnt_nxt = `LWD_CNT_ZERO;
    end else if (stop_entry) begin
      cnt_nxt = `LWD_CNT_ZERO;
    end else if (!cfg.enable) begin
      cnt_nxt = `LWD_CNT_ZERO;
    end else if (i_debug_mode) begin
      cnt_nxt = cnt_r;
    end else if (i_stop_mode) begin
      cnt_nxt = cnt_r;
    end else if (step) begin
      if (cnt_r + `LWD_CNT_ONE >= limit) begin
        ovf     = 1'h1;
        cnt_nxt = `LWD_CNT_ZERO;
      end else begin
        cnt_nxt = cnt_r + `LWD_CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r    <= `LWD_CNT_ZERO;
      stop_d_r <= 1'h0;
    end else begin
      cnt_r    <= cnt_nxt;
      stop_d_r <= stop_d_nxt;
    end
  end

  // ****************************************
  // reset pulse
  // ****************************************
  // stretched so that a slow system reset path still catches it
  always_comb begin
    hold_nxt = hold_r;
    if (ovf) begin
      hold_nxt = `LWD_RST_PULSE;
    end else if (hold_r != `LWD_HOLD_ZERO) begin
      hold_nxt = hold_r - `LWD_HOLD_ONE;
    end
    // one overflow cycle plus fifteen hold cycles gives sixteen
    fire_nxt = ovf || (hold_r != `LWD_HOLD_ZERO);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fire_r <= 1'h0;
      hold_r <= `LWD_HOLD_ZERO;
    end else begin
      fire_r <= fire_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ****************************************
  // reset cause flag
  // ****************************************
  always_comb begin
    cause_nxt = cause_r;
    if (ovf) begin
      cause_nxt = 1'h1;
    end else if (i_other_reset) begin
      cause_nxt = 1'h0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause_r <= 1'h0;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ****************************************
  // settings mirror
  // ****************************************
  always_comb begin
    en_nxt   = cfg.enable;
    clks_nxt = cfg.clk_sel;
    tos_nxt  = cfg.to_sel;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_r   <= `LWD_RST_ENABLE;
      clks_r <= `LWD_RST_CLKSEL;
      tos_r  <= `LWD_RST_TOSEL;
    end else begin
      en_r   <= en_nxt;
      clks_r <= clks_nxt;
      tos_r  <= tos_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output comes straight from a flip-flop
  assign o_sys_reset      = fire_r;
  assign o_cause_watchdog = cause_r;
  assign o_enable         = en_r;
  assign o_clk_sel        = clks_r;
  assign o_to_sel         = tos_r;
endmodule
`default_nettype wire

// *** dv/lwd_top_asserts.sv ***
// Purpose: port checker for lwd_top
// Assumes: one clock domain
// Notes:   settings can only move away from reset values once
`timescale 1ns/1ps
`default_nettype none
module lwd_top_asserts (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_debug_mode,
  input wire logic i_stop_mode,
  input wire logic i_other_reset,
  input wire logic o_sys_reset,
  input wire logic o_cause_watchdog,
  input wire logic o_enable,
  input wire logic o_clk_sel,
  input wire logic o_to_sel
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_reset_defaults: assert property ($rose(i_rst_n) |-> o_enable && !o_clk_sel && o_to_sel)
    else $error("settings not at reset values");
  a_disabled_quiet: assert property (!o_enable && !o_sys_reset |=> !o_sys_reset)
    else $error("reset while disabled");
  a_pulse_width: assert property ($rose(o_sys_reset) |-> o_sys_reset[*8] ##1 o_sys_reset[*8] ##1 !o_sys_reset)
    else $error("reset pulse not 16 cycles");
  a_cause_set: assert property ($rose(o_sys_reset) |-> ##[0:2] o_cause_watchdog)
    else $error("cause flag not set");
  a_cause_clear: assert property (i_other_reset ##1 !$rose(o_sys_reset) |-> !o_cause_watchdog)
    else $error("cause flag not cleared");
  a_enable_locked: assert property (!o_enable |=> !o_enable)
    else $error("enable changed after lock");
  a_clksel_locked: assert property (o_clk_sel |=> o_clk_sel)
    else $error("clock select changed after lock");
  a_tosel_locked: assert property (!o_to_sel |=> !o_to_sel)
    else $error("timeout select changed after lock");
  a_debug_hold: assert property (i_debug_mode[*3] |-> !$rose(o_sys_reset))
    else $error("overflow during debug");
  a_stop_hold: assert property ((o_clk_sel && i_stop_mode)[*3] |-> !$rose(o_sys_reset))
    else $error("overflow during stop");
  c_fire: cover property ($rose(o_sys_reset));
  c_disabled: cover property (!o_enable);
  c_bus_stop: cover property (o_clk_sel && i_stop_mode);
endmodule
`default_nettype wire

// *** dv/tb_lwd_top.sv ***
// Purpose: self-checking bench for lwd_top
// Assumes: low-power ticks every fourth cycle
// Notes:   long bus timeout only checked as quiet, a full run costs too many cycles
`timescale 1ns/1ps
`default_nettype none
module tb_lwd_top;
  logic i_mclk, i_rst_n, i_lp_tick, i_cause_wr, i_opt1_wr, i_opt1_enable, i_opt1_to_sel;
  logic i_opt2_wr, i_opt2_clk_sel, i_debug_mode, i_stop_mode, i_other_reset;
  logic o_sys_reset, o_cause_watchdog, o_enable, o_clk_sel, o_to_sel;
  int   mismatches = 0, cmp_count = 0, cyc = 0, c;
  // enable, clock select, timeout select, count
  int   rows[5][4] = '{'{1,0,0,32}, '{1,0,1,256}, '{1,1,0,8192}, '{1,1,1,262144}, '{0,0,0,32}};
  lwd_top i_lwd_top (
    .i_mclk           (i_mclk),
    .i_rst_n          (i_rst_n),
    .i_lp_tick        (i_lp_tick),
    .i_cause_wr       (i_cause_wr),
    .i_opt1_wr        (i_opt1_wr),
    .i_opt1_enable    (i_opt1_enable),
    .i_opt1_to_sel    (i_opt1_to_sel),
    .i_opt2_wr        (i_opt2_wr),
    .i_opt2_clk_sel   (i_opt2_clk_sel),
    .i_debug_mode     (i_debug_mode),
    .i_stop_mode      (i_stop_mode),
    .i_other_reset    (i_other_reset),
    .o_sys_reset      (o_sys_reset),
    .o_cause_watchdog (o_cause_watchdog),
    .o_enable         (o_enable),
    .o_clk_sel        (o_clk_sel),
    .o_to_sel         (o_to_sel)
  );
  initial begin
    i_mclk = 1'h0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // four-state arguments so an unknown output cannot pass as zero
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
      mismatches++;
    end
  endtask
  task automatic reset_dut();
    @(posedge i_mclk);
    i_rst_n <= 1'h0;
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    @(posedge i_mclk);
  endtask
  task automatic cfg(logic en, logic to, logic clk);
    @(posedge i_mclk);
    i_opt1_enable <= en;
    i_opt1_to_sel <= to;
    i_opt2_clk_sel <= clk;
    i_opt1_wr <= 1'h1;
    i_opt2_wr <= 1'h1;
    @(posedge i_mclk);
    i_opt1_wr <= 1'h0;
    i_opt2_wr <= 1'h0;
    repeat (3) @(posedge i_mclk);
  endtask
  task automatic cause_pulse();
    @(posedge i_mclk);
    i_cause_wr <= 1'h1;
    @(posedge i_mclk);
    i_cause_wr <= 1'h0;
  endtask
  // ticks spaced wider than the overflow latency keep the tick count exact
  task automatic run(logic lp, int n);
    c = 0;
    for (int k = 0; k < n && o_sys_reset !== 1'h1; k++) begin
      @(posedge i_mclk);
      i_lp_tick <= lp && k % 4 == 0;
      c += int'(!lp || k % 4 == 0);
      @(negedge i_mclk);
    end
    @(posedge i_mclk);
    i_lp_tick <= 1'h0;
  endtask
  initial begin
    {i_rst_n, i_lp_tick, i_cause_wr, i_opt1_wr, i_opt1_enable, i_opt1_to_sel} = '0;
    {i_opt2_wr, i_opt2_clk_sel, i_debug_mode, i_stop_mode, i_other_reset} = '0;
    for (int r = 0; r < 5; r++) begin
      reset_dut();
      cfg(rows[r][0][0], rows[r][2][0], rows[r][1][0]);
      cfg(!rows[r][0], !rows[r][2], !rows[r][1]);
      chk("enable", rows[r][0], o_enable);
      chk("clk_sel", rows[r][1], o_clk_sel);
      chk("to_sel", rows[r][2], o_to_sel);
      cause_pulse();
      run(!rows[r][1][0], 9000);
      if (!rows[r][0] || rows[r][3] > 9000) chk("quiet", 0, o_sys_reset);
      else if (rows[r][1] != 0) chk("bus_span", 1, (c >= rows[r][3] - 2 && c <= rows[r][3] + 3));
      else chk("lp_count", rows[r][3], c);
      $display("row %0d done", r);
    end
    reset_dut();
    chk("def_enable", 1, o_enable);
    chk("def_clk_sel", 0, o_clk_sel);
    chk("def_to_sel", 1, o_to_sel);
    cfg(1'h1, 1'h0, 1'h0);
    run(1'h1, 80);
    cause_pulse();
    run(1'h1, 80);
    i_stop_mode <= 1'h1;
    repeat (4) @(posedge i_mclk);
    i_stop_mode <= 1'h0;
    i_debug_mode <= 1'h1;
    run(1'h1, 160);
    i_debug_mode <= 1'h0;
    run(1'h1, 9000);
    chk("resume_count", 32, c);
    repeat (20) @(posedge i_mclk);
    chk("cause_set", 1, o_cause_watchdog);
    i_other_reset <= 1'h1;
    @(posedge i_mclk);
    i_other_reset <= 1'h0;
    repeat (2) @(posedge i_mclk);
    chk("cause_clear", 0, o_cause_watchdog);
    $display("low-power hold test done");
    reset_dut();
    cfg(1'h1, 1'h0, 1'h1);
    cause_pulse();
    run(1'h0, 4000);
    i_stop_mode <= 1'h1;
    repeat (5000) @(posedge i_mclk);
    i_stop_mode <= 1'h0;
    run(1'h0, 9000);
    chk("bus_resume", 1, (c >= 4188 && c <= 4196));
    $display("bus stop test done");
    complete_run();
  end
endmodule
bind lwd_top lwd_top_asserts i_lwd_top_asserts (
  .i_mclk           (i_mclk),
  .i_rst_n          (i_rst_n),
  .i_debug_mode     (i_debug_mode),
  .i_stop_mode      (i_stop_mode),
  .i_other_reset    (i_other_reset),
  .o_sys_reset      (o_sys_reset),
  .o_cause_watchdog (o_cause_watchdog),
  .o_enable         (o_enable),
  .o_clk_sel        (o_clk_sel),
  .o_to_sel         (o_to_sel)
);
`default_nettype wire
